// ==== hdl/pia_regs.svh ====
/*
  Register indices, field positions, reset values and fixed codes of the
  priority interrupt arbiter.
  Assumes an APB slave with byte addressing: byte address is four times the index.
*/
`ifndef PIA_REGS_SVH
`define PIA_REGS_SVH

// Register indices (byte address = index * 4)
`define PIA_IDX_CTRL 10'h0e6
`define PIA_IDX_EMR 10'h0e8
`define PIA_IDX_PRIO 10'h0e9
`define PIA_IDX_VEC 10'h0ea
`define PIA_IDX_ISEG 10'h0eb
`define PIA_IDX_CSEG 10'h0ec
`define PIA_IDX_NEST 10'h0ed
`define PIA_IDX_STAT 10'h0ee

// Central interrupt control fields
`define PIA_CTRL_PRIO_LSB 0
`define PIA_CTRL_MODE_BIT 3
`define PIA_CTRL_EN_BIT 4
`define PIA_CTRL_TLM_BIT 5
`define PIA_CTRL_TLA_BIT 6
`define PIA_CTRL_RST 8'h07

// Extended mode two: segment save mode bit
`define PIA_EMR_SAVE_BIT 6
`define PIA_EMR_RST 8'h00

// Priority levels and vectors
`define PIA_PRIO_LOWEST 3'h7
`define PIA_TOP_CHAN 4'h8
`define PIA_TOP_VECTOR 8'h04
`define PIA_VEC_BASE_MASK 8'hf0

`endif

// ==== hdl/pia_pkg.sv ====
/*
  Types of the priority interrupt arbiter: sequencer states and the state record.
  Assumes pia_regs.svh is not needed here; constants live in the header.
*/
package pia_pkg;

  typedef enum logic [10:0] {
    PIA_IDLE = 11'h001,
    PIA_PUSH_PCL = 11'h002,
    PIA_PUSH_PCH = 11'h004,
    PIA_PUSH_CS = 11'h008,
    PIA_PUSH_FLG = 11'h010,
    PIA_VEC_HI = 11'h020,
    PIA_VEC_LO = 11'h040,
    PIA_POP_FLG = 11'h080,
    PIA_POP_CS = 11'h100,
    PIA_POP_PCH = 11'h200,
    PIA_POP_PCL = 11'h400
  } pia_state_t;

  typedef struct packed {
    pia_state_t st;
    logic [2:0] cur_prio;
    logic mode_nested;
    logic irq_en;
    logic top_maskable;
    logic top_active;
    logic save_mode;
    logic [23:0] prio;
    logic [7:0] vec_base;
    logic [7:0] iseg;
    logic [7:0] cseg;
    logic [7:0] nest;
    logic use_iseg;
    logic [3:0] win_chan;
    logic [7:0] win_vec;
    logic [15:0] pc_save;
    logic [7:0] flags_save;
    logic [7:0] wdata;
    logic [7:0] pc_hi;
    logic [15:0] pc_out;
    logic pc_load;
    logic [7:0] flags_out;
    logic flags_load;
    logic irq_taken;
    logic [31:0] prdata;
    logic pslverr;
  } pia_state_rec_t;

endpackage

// ==== hdl/pia_priority_interrupt_arbiter.sv ====
/*
  Priority interrupt arbiter: per-instruction arbitration of eight channels,
  DMA requests and a top-level source, plus interrupt entry and return
  sequencing towards the core's stack, program counter and vector fetch.
  Assumes the core presents stack top on stack_rdata and vector table bytes on
  mem_rdata in the same cycle as the pop or read strobe, and that request
  inputs come from logic on pclk.
*/
`include "pia_regs.svh"

// Functional notes
// - Save mode 0: interrupt segment replaces code segment; push PC and flags only.
// - Save mode 1: push old code segment too, then load it from interrupt segment.
// - Save mode 1: return also pops code segment from the stack.
// - Compatibility mode: routine stays in one 64K segment; far jumps change unused register.
// - Each channel has a 3-bit level, 0 highest and 7 lowest.
// - Top level beats all, is never interrupted, maskable or not by choice.
// - Current priority is 3 bits in central control register, 7 at reset.
// - Arbitration each instruction compares all channel requests, DMA included.
// - Interrupt winner acknowledged only if its level is below current priority.
// - Level 7 requests are never acknowledged, allowing polling.
// - A routine at level N is not interrupted by level N; concurrent mode lets level N in once enable is set.
// - Equal levels resolved by fixed chain A0, A1, B0, B1, C0, C1, D0, D1.
// - Current priority is readable and writable by software any time.
// - Mode bit: 0 concurrent (reset), 1 nested.
// - Concurrent mode leaves current priority unchanged on acknowledge.
// - Entry: clear enable, push PC low, PC high, segment if saved, flags, load vector.
// - Return: pop flags, segment if saved, PC high, PC low, set enable.
// - Requests with enable cleared wait until the next enable instruction.
// - Concurrent mode keeps no trace of the serviced level.
// - Queued requests are serviced one by one in priority order.
// - Nested: history bit at old priority set, priority loaded; return restores it.
// - Save mode sits in bit 6 of extended mode two, cleared at reset.
// - Vector table is first 256 bytes of the interrupt segment.
// - Top-level vector sits at 0004h and 0005h of the interrupt segment.

module pia_priority_interrupt_arbiter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_boundary,
  input wire logic [7:0] chan_req,
  input wire logic [7:0] dma_req,
  input wire logic top_req,
  input wire logic enable_exec,
  input wire logic iret_req,
  input wire logic cs_write,
  input wire logic [7:0] cs_wdata,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] flags_in,
  output logic stack_push,
  output logic stack_pop,
  output logic [7:0] stack_wdata,
  input wire logic [7:0] stack_rdata,
  output logic mem_rd,
  output logic [23:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  output logic [15:0] pc_out,
  output logic pc_load,
  output logic [7:0] flags_out,
  output logic flags_load,
  output logic [7:0] active_segment,
  output logic irq_taken,
  output logic dma_grant,
  output logic [3:0] win_chan,
  output logic [7:0] win_vector,
  output logic busy
);

  // All state lives in one record: s_q holds it, s_d is its next value
  // Single-cycle strobes default low in s_d
  // So each strobe stands for exactly one cycle after its edge
  // Trade: a wide record, but one reset point and one register process
  pia_pkg::pia_state_rec_t s_q;
  pia_pkg::pia_state_rec_t s_d;

  logic [9:0] reg_idx;
  logic setup;
  logic wr_en;
  logic hit;
  logic [31:0] rd_val;
  logic [2:0] best_prio;
  logic [2:0] best_idx;
  logic best_valid;
  logic top_ok;
  logic int_ok;
  logic arb_go;
  logic [3:0] resume_lvl;

  // Reset images kept as words, so single fields are sliced without size loss
  localparam logic [7:0] ctrl_reset = `PIA_CTRL_RST;
  localparam logic [7:0] emr_reset = `PIA_EMR_RST;

  // Level of channel i from the packed priority word
  function automatic logic [2:0] prio_of(input logic [23:0] p, input int unsigned i);
    prio_of = p[3*i +: 3];
  endfunction

  // Lowest set bit of the history: most recently suspended level
  // Returns 8 when the history is empty: nothing to restore
  function automatic logic [3:0] lowest_set(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    lowest_set = r;
  endfunction

  // Bus side: read data latched in the setup cycle
  // Pready tied high, so every access phase lasts one cycle
  // Write lands at the access edge only, never in setup
  // Unmapped index: error flag raised, data zero, write dropped
  // Low two address bits ignored: registers are word aligned
  assign reg_idx = paddr[11:2];
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite;
  assign pready = 1'b1;
  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr;

  // Address decode shared by read capture and error flag
  always_comb begin
    hit = 1'b1;
    case (reg_idx)
      `PIA_IDX_CTRL, `PIA_IDX_EMR, `PIA_IDX_PRIO, `PIA_IDX_VEC,
      `PIA_IDX_ISEG, `PIA_IDX_CSEG, `PIA_IDX_NEST, `PIA_IDX_STAT: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Read mux; unused bits read as zero
  always_comb begin
    rd_val = 32'h0000_0000;
    case (reg_idx)
      `PIA_IDX_CTRL: begin
        rd_val[`PIA_CTRL_PRIO_LSB +: 3] = s_q.cur_prio;
        rd_val[`PIA_CTRL_MODE_BIT] = s_q.mode_nested;
        rd_val[`PIA_CTRL_EN_BIT] = s_q.irq_en;
        rd_val[`PIA_CTRL_TLM_BIT] = s_q.top_maskable;
        rd_val[`PIA_CTRL_TLA_BIT] = s_q.top_active;
      end
      `PIA_IDX_EMR: rd_val[`PIA_EMR_SAVE_BIT] = s_q.save_mode;
      `PIA_IDX_PRIO: rd_val[23:0] = s_q.prio;
      `PIA_IDX_VEC: rd_val[7:0] = s_q.vec_base;
      `PIA_IDX_ISEG: rd_val[7:0] = s_q.iseg;
      `PIA_IDX_CSEG: rd_val[7:0] = s_q.cseg;
      `PIA_IDX_NEST: rd_val[7:0] = s_q.nest;
      `PIA_IDX_STAT: rd_val[15:0] = {s_q.win_vec, busy, s_q.use_iseg, 2'b00, s_q.win_chan};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Scan runs from channel 7 down to 0 with a less-or-equal compare
  // So on a tie the lower index, earlier in the fixed chain, is kept
  // A DMA request competes on its channel's level like an interrupt
  // Level 7 can still win here; the acknowledge stage refuses it
  // Arbitration: lowest level wins, ties go to the lower channel index
  always_comb begin
    best_prio = `PIA_PRIO_LOWEST;
    best_idx = 3'h0;
    best_valid = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if ((chan_req[i] | dma_req[i]) && (!best_valid || prio_of(s_q.prio, i) <= best_prio)) begin
        best_prio = prio_of(s_q.prio, i);
        best_idx = 3'(i);
        best_valid = 1'b1;
      end
    end
  end

  // Arbitration only at an instruction boundary with the sequencer idle
  assign arb_go = instr_boundary & (s_q.st == pia_pkg::PIA_IDLE) & ~iret_req;
  // Top level overrides; a running top-level routine blocks everything
  assign top_ok = top_req & ~s_q.top_active & (s_q.irq_en | ~s_q.top_maskable);
  // Strict compare also keeps level 7 and same-level requests out
  assign int_ok = best_valid & ~dma_req[best_idx] & s_q.irq_en & ~s_q.top_active
                  & (best_prio < s_q.cur_prio) & (best_prio != `PIA_PRIO_LOWEST);
  // DMA needs no priority compare, only the win
  assign dma_grant = arb_go & ~top_ok & best_valid & dma_req[best_idx] & ~s_q.top_active;

  // Strobes are plain state decodes: no extra flop, no cycle lost
  // The core must answer pops and table reads in the same cycle
  // Limitation: a slow partner would need a wait input, not provided
  // Handshake strobes decoded straight from the state
  assign stack_push = (s_q.st == pia_pkg::PIA_PUSH_PCL) | (s_q.st == pia_pkg::PIA_PUSH_PCH)
                      | (s_q.st == pia_pkg::PIA_PUSH_CS) | (s_q.st == pia_pkg::PIA_PUSH_FLG);
  assign stack_pop = (s_q.st == pia_pkg::PIA_POP_FLG) | (s_q.st == pia_pkg::PIA_POP_CS)
                     | (s_q.st == pia_pkg::PIA_POP_PCH) | (s_q.st == pia_pkg::PIA_POP_PCL);
  assign mem_rd = (s_q.st == pia_pkg::PIA_VEC_HI) | (s_q.st == pia_pkg::PIA_VEC_LO);
  // Vector bytes from the first 256 bytes of the interrupt segment, high byte first
  assign mem_addr = {s_q.iseg, 8'h00, s_q.win_vec | {7'h00, s_q.st == pia_pkg::PIA_VEC_LO}};
  assign stack_wdata = s_q.wdata;
  assign busy = (s_q.st != pia_pkg::PIA_IDLE);
  // History decode shared by the return step's test, restore and clear
  assign resume_lvl = lowest_set(s_q.nest);
  // Compatibility mode runs the routine from the interrupt segment
  assign active_segment = s_q.use_iseg ? s_q.iseg : s_q.cseg;
  assign pc_out = s_q.pc_out;
  assign pc_load = s_q.pc_load;
  assign flags_out = s_q.flags_out;
  assign flags_load = s_q.flags_load;
  assign irq_taken = s_q.irq_taken;
  assign win_chan = s_q.win_chan;
  assign win_vector = s_q.win_vec;

  // Writer order: bus write, far jump, enable instruction, sequencer
  // Later assignments win, so hardware beats a same-cycle bus write
  // Cost: software cannot override a running entry or return
  // Next state: software writes first, hardware updates after so they win
  always_comb begin
    s_d = s_q;
    s_d.pc_load = 1'b0;
    s_d.flags_load = 1'b0;
    s_d.irq_taken = 1'b0;
    s_d.pslverr = 1'b0;
    if (setup) begin
      s_d.prdata = hit ? rd_val : 32'h0000_0000;
      s_d.pslverr = ~hit;
    end else if (psel & penable) begin
      s_d.pslverr = s_q.pslverr;
    end

    // Register writes at the access phase
    if (wr_en) begin
      case (reg_idx)
        `PIA_IDX_CTRL: begin
          s_d.cur_prio = pwdata[`PIA_CTRL_PRIO_LSB +: 3];
          s_d.mode_nested = pwdata[`PIA_CTRL_MODE_BIT];
          s_d.irq_en = pwdata[`PIA_CTRL_EN_BIT];
          s_d.top_maskable = pwdata[`PIA_CTRL_TLM_BIT];
        end
        `PIA_IDX_EMR: s_d.save_mode = pwdata[`PIA_EMR_SAVE_BIT];
        `PIA_IDX_PRIO: s_d.prio = pwdata[23:0];
        `PIA_IDX_VEC: s_d.vec_base = pwdata[7:0] & `PIA_VEC_BASE_MASK;
        `PIA_IDX_ISEG: s_d.iseg = pwdata[7:0];
        `PIA_IDX_CSEG: s_d.cseg = pwdata[7:0];
        `PIA_IDX_NEST: s_d.nest = pwdata[7:0];
        default: s_d.cur_prio = s_d.cur_prio;
      endcase
    end

    // Far jump or call from the core always lands in the code segment register
    if (cs_write) begin
      s_d.cseg = cs_wdata;
    end
    // Enable instruction releases pending requests
    if (enable_exec) begin
      s_d.irq_en = 1'b1;
    end

    // Sequencer: idle, five or six entry steps, three or four return steps
    // Return is taken before arbitration when both come in one cycle
    // Entry snapshots pc_in and flags_in at the acknowledge edge
    case (s_q.st)
      pia_pkg::PIA_IDLE: begin
        if (iret_req) begin
          s_d.st = pia_pkg::PIA_POP_FLG;
        end else if (arb_go && (top_ok || int_ok)) begin
          s_d.irq_taken = 1'b1;
          s_d.irq_en = 1'b0;
          s_d.pc_save = pc_in;
          s_d.flags_save = flags_in;
          s_d.wdata = pc_in[7:0];
          s_d.st = pia_pkg::PIA_PUSH_PCL;
          if (top_ok) begin
            s_d.top_active = 1'b1;
            s_d.win_chan = `PIA_TOP_CHAN;
            s_d.win_vec = `PIA_TOP_VECTOR;
          end else begin
            s_d.win_chan = {1'b0, best_idx};
            s_d.win_vec = s_q.vec_base | {4'h0, best_idx, 1'b0};
            if (s_q.mode_nested) begin
              s_d.nest[s_q.cur_prio] = 1'b1;
              s_d.cur_prio = best_prio;
            end
            // Concurrent mode: current priority untouched, no level kept
          end
        end
      end
      pia_pkg::PIA_PUSH_PCL: begin
        s_d.wdata = s_q.pc_save[15:8];
        s_d.st = pia_pkg::PIA_PUSH_PCH;
      end
      pia_pkg::PIA_PUSH_PCH: begin
        if (s_q.save_mode) begin
          s_d.wdata = s_q.cseg;
          s_d.st = pia_pkg::PIA_PUSH_CS;
        end else begin
          s_d.wdata = s_q.flags_save;
          s_d.st = pia_pkg::PIA_PUSH_FLG;
        end
      end
      pia_pkg::PIA_PUSH_CS: begin
        s_d.wdata = s_q.flags_save;
        s_d.st = pia_pkg::PIA_PUSH_FLG;
      end
      pia_pkg::PIA_PUSH_FLG: begin
        s_d.st = pia_pkg::PIA_VEC_HI;
      end
      pia_pkg::PIA_VEC_HI: begin
        s_d.pc_hi = mem_rdata;
        s_d.st = pia_pkg::PIA_VEC_LO;
      end
      pia_pkg::PIA_VEC_LO: begin
        s_d.pc_out = {s_q.pc_hi, mem_rdata};
        s_d.pc_load = 1'b1;
        if (s_q.save_mode) begin
          s_d.cseg = s_q.iseg;
          s_d.use_iseg = 1'b0;
        end else begin
          s_d.use_iseg = 1'b1;
        end
        s_d.st = pia_pkg::PIA_IDLE;
      end
      pia_pkg::PIA_POP_FLG: begin
        s_d.flags_out = stack_rdata;
        s_d.flags_load = 1'b1;
        s_d.st = s_q.save_mode ? pia_pkg::PIA_POP_CS : pia_pkg::PIA_POP_PCH;
      end
      pia_pkg::PIA_POP_CS: begin
        s_d.cseg = stack_rdata;
        s_d.st = pia_pkg::PIA_POP_PCH;
      end
      pia_pkg::PIA_POP_PCH: begin
        s_d.pc_hi = stack_rdata;
        s_d.st = pia_pkg::PIA_POP_PCL;
      end
      pia_pkg::PIA_POP_PCL: begin
        s_d.pc_out = {s_q.pc_hi, stack_rdata};
        s_d.pc_load = 1'b1;
        s_d.irq_en = 1'b1;
        s_d.use_iseg = 1'b0;
        // Only the top-level routine can be running while it is active
        s_d.top_active = 1'b0;
        if (s_q.mode_nested && !s_q.top_active && resume_lvl != 4'h8) begin
          s_d.cur_prio = resume_lvl[2:0];
          s_d.nest[resume_lvl[2:0]] = 1'b0;
        end
        // Back to idle lets the next queued request win at the next boundary
        s_d.st = pia_pkg::PIA_IDLE;
      end
      default: s_d.st = pia_pkg::PIA_IDLE;
    endcase
  end

  // Fields with no named reset value start at zero
  // Reset images are taken from whole words, then sliced per field
  // Limitation: release of reset must meet timing at the system level
  // State register; constants only under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.st <= pia_pkg::PIA_IDLE;
      s_q.cur_prio <= ctrl_reset[`PIA_CTRL_PRIO_LSB +: 3];
      s_q.save_mode <= emr_reset[`PIA_EMR_SAVE_BIT];
      s_q.mode_nested <= ctrl_reset[`PIA_CTRL_MODE_BIT];
    end else begin
      s_q <= s_d;
    end
  end

endmodule // pia_priority_interrupt_arbiter

// ==== testbench/pia_core_model.sv ====
/*
  Behavioural core side of the arbiter: byte stack and vector table bytes.
  Assumes push and pop strobes on pclk, with read data wanted in the same cycle.
*/
module pia_core_model (
  input logic pclk,
  input logic stack_push,
  input logic stack_pop,
  input logic [7:0] stack_wdata,
  output logic [7:0] stack_rdata,
  input logic mem_rd,
  input logic [23:0] mem_addr,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:15];
  logic [3:0] sp = 4'h0;
  initial foreach (mem[i]) mem[i] = 8'h00;
  // Inverted when not popped, so a stale byte never looks valid
  assign stack_rdata = stack_pop ? mem[sp - 4'h1] : ~mem[sp - 4'h1];
  // Table byte from the low address: every vector differs
  assign mem_rdata = mem_rd ? mem_addr[7:0] + 8'h10 : ~mem_addr[7:0];
  // Stack moves on the edge that takes the strobe
  always @(posedge pclk) begin
    if (stack_push) begin
      mem[sp] <= stack_wdata;
      sp <= sp + 4'h1;
    end
    if (stack_pop) sp <= sp - 4'h1;
  end
endmodule // pia_core_model

// ==== testbench/pia_sva.sv ====
/*
  Concurrent checks on the arbiter's core-side sequencing.
  Bound to the top module; sees its ports only.
*/
module pia_sva (
  input logic pclk,
  input logic presetn,
  input logic instr_boundary,
  input logic iret_req,
  input logic busy,
  input logic irq_taken,
  input logic stack_push,
  input logic stack_pop,
  input logic mem_rd,
  input logic pc_load,
  input logic flags_load,
  input logic dma_grant,
  input logic [3:0] win_chan,
  input logic [7:0] win_vector
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Entry frame and its length
  a_entry_push: assert property (irq_taken |-> stack_push [*3])
    else $error("entry push run too short");
  a_entry_len: assert property (irq_taken |-> ##[5:6] pc_load)
    else $error("entry did not load the vector");
  a_vec_fetch: assert property ($fell(mem_rd) |-> pc_load && $past(mem_rd, 2))
    else $error("vector fetch not two bytes then load");
  a_ack_boundary: assert property (irq_taken |-> $past(instr_boundary) && !$past(busy))
    else $error("acknowledge outside an idle boundary");
  // DMA wins end in a grant, never an entry
  a_dma_boundary: assert property (dma_grant |-> instr_boundary && !busy)
    else $error("grant outside a boundary");
  a_dma_no_entry: assert property (dma_grant |=> !irq_taken)
    else $error("entry after a grant");
  a_win_stable: assert property (busy && $past(busy) |-> $stable(win_chan) && $stable(win_vector))
    else $error("winner changed while busy");
  a_top_vector: assert property (irq_taken && win_chan == 4'h8 |-> win_vector == 8'h04)
    else $error("top level vector wrong");
  // Return: flags first, then the rest within the save-mode bound
  a_ret_flags: assert property (iret_req && !busy |=> stack_pop ##1 flags_load)
    else $error("return did not pop flags first");
  a_ret_len: assert property (iret_req && !busy |-> ##[4:5] pc_load)
    else $error("return did not reload the pc");
endmodule // pia_sva

bind pia_priority_interrupt_arbiter pia_sva i_sva (.*);

// ==== testbench/test_priority_interrupt_arbiter.sv ====
/*
  Self-checking bench for the priority interrupt arbiter: APB register
  tasks, core strobes and a behavioural stack and vector partner.
  Assumes APB answers on the access edge and registers sit at index * 4.
*/
`include "pia_regs.svh"
module test_priority_interrupt_arbiter;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic instr_boundary = 1'b0;
  logic [7:0] chan_req = 8'h00;
  logic [7:0] dma_req = 8'h00;
  logic top_req = 1'b0;
  logic enable_exec = 1'b0;
  logic iret_req = 1'b0;
  logic cs_write = 1'b0;
  logic [7:0] cs_wdata = 8'h00;
  logic [15:0] pc_in = 16'h1234;
  logic [7:0] flags_in = 8'ha5;
  logic pready, pslverr, stack_push, stack_pop, mem_rd, pc_load, flags_load, irq_taken, dma_grant, busy;
  logic [7:0] stack_wdata, stack_rdata, mem_rdata, flags_out, active_segment, win_vector;
  logic [31:0] prdata, rd;
  logic [23:0] mem_addr;
  logic [15:0] pc_out;
  logic [3:0] win_chan;
  logic err, g;
  int n_mismatch = 0;
  int total_checks = 0;

  pia_priority_interrupt_arbiter i_dut (.*);
  pia_core_model i_core (.*);

  // 100 MHz clock
  always #5 pclk = ~pclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; an idle edge after it keeps psel from toggling twice
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    apb(1'b1, {i, 2'b00}, d);
  endtask

  task automatic rchk(input logic [9:0] i, input logic [31:0] exp);
    apb(1'b0, {i, 2'b00}, 32'h0);
    chk(rd, exp);
  endtask

  // One boundary with these requests, then the whole entry if any
  task automatic arb(input logic [7:0] rq, input logic tp, input logic ack);
    chan_req <= rq;
    top_req <= tp;
    instr_boundary <= 1'b1;
    @(posedge pclk);
    g = dma_grant;
    instr_boundary <= 1'b0;
    @(posedge pclk);
    chk(irq_taken, ack);
    chan_req <= 8'h00;
    top_req <= 1'b0;
    for (int i = 0; i < 20 && busy; i++) @(posedge pclk);
    @(posedge pclk);
  endtask

  task automatic pulse_en;
    enable_exec <= 1'b1;
    @(posedge pclk);
    enable_exec <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic ret;
    iret_req <= 1'b1;
    @(posedge pclk);
    iret_req <= 1'b0;
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 20 && busy; i++) @(posedge pclk);
    @(posedge pclk);
  endtask

  task automatic results;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Whole run is a few hundred cycles; this span leaves ample margin
  initial begin
    #50us;
    n_mismatch++;
    results();
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(`PIA_IDX_CTRL, 32'h07);
    rchk(`PIA_IDX_EMR, 32'h00);
    apb(1'b0, 12'h000, 32'h0);
    chk(err, 1'b1);
    wr(`PIA_IDX_CTRL, 32'h03);
    rchk(`PIA_IDX_CTRL, 32'h03);
    wr(`PIA_IDX_PRIO, 32'hff94df);
    wr(`PIA_IDX_VEC, 32'h40);
    wr(`PIA_IDX_ISEG, 32'h2a);
    wr(`PIA_IDX_CSEG, 32'h33);
    // Refusals: enable clear, level not below current, level 7
    arb(8'h08, 1'b0, 1'b0);
    pulse_en();
    arb(8'h02, 1'b0, 1'b0);
    wr(`PIA_IDX_CTRL, 32'h17);
    arb(8'h01, 1'b0, 1'b0);
    // Equal levels, compatibility frame, far jump inside the routine
    arb(8'h06, 1'b0, 1'b1);
    chk(win_chan, 4'h1);
    chk(win_vector, 8'h42);
    chk(pc_out, 16'h5253);
    chk({i_core.mem[0], i_core.mem[1], i_core.mem[2]}, 24'h3412a5);
    chk(active_segment, 8'h2a);
    rchk(`PIA_IDX_CTRL, 32'h07);
    cs_write <= 1'b1;
    cs_wdata <= 8'h44;
    @(posedge pclk);
    cs_write <= 1'b0;
    @(posedge pclk);
    chk(active_segment, 8'h2a);
    arb(8'h10, 1'b0, 1'b0);
    ret();
    chk(pc_out, 16'h1234);
    chk(flags_out, 8'ha5);
    chk(i_core.sp, 4'h0);
    chk(active_segment, 8'h44);
    rchk(`PIA_IDX_CTRL, 32'h17);
    // Queued pair served in order; a lower level gets in once enabled
    arb(8'h18, 1'b0, 1'b1);
    chk(win_chan, 4'h4);
    pulse_en();
    arb(8'h08, 1'b0, 1'b1);
    chk(win_chan, 4'h3);
    ret();
    ret();
    chk(i_core.sp, 4'h0);
    // Segment save mode frame and its return
    wr(`PIA_IDX_EMR, 32'h40);
    rchk(`PIA_IDX_EMR, 32'h40);
    arb(8'h10, 1'b0, 1'b1);
    chk({i_core.mem[0], i_core.mem[1], i_core.mem[2], i_core.mem[3]}, 32'h341244a5);
    rchk(`PIA_IDX_CSEG, 32'h2a);
    ret();
    rchk(`PIA_IDX_CSEG, 32'h44);
    wr(`PIA_IDX_EMR, 32'h00);
    // Nested mode: history, same level refused, restore
    wr(`PIA_IDX_CTRL, 32'h1f);
    arb(8'h08, 1'b0, 1'b1);
    rchk(`PIA_IDX_CTRL, 32'h0a);
    rchk(`PIA_IDX_NEST, 32'h80);
    pulse_en();
    arb(8'h08, 1'b0, 1'b0);
    ret();
    rchk(`PIA_IDX_CTRL, 32'h1f);
    rchk(`PIA_IDX_NEST, 32'h00);
    // Top level beats a channel and cannot be interrupted
    arb(8'h10, 1'b1, 1'b1);
    chk(win_chan, 4'h8);
    chk(pc_out, 16'h1415);
    rchk(`PIA_IDX_CTRL, 32'h4f);
    rchk(`PIA_IDX_STAT, 32'h0448);
    pulse_en();
    arb(8'h10, 1'b0, 1'b0);
    ret();
    // Top level made maskable is held off while the enable is clear
    wr(`PIA_IDX_CTRL, 32'h2f);
    arb(8'h00, 1'b1, 1'b0);
    // DMA on a channel takes the grant instead of an entry
    dma_req <= 8'h10;
    arb(8'h10, 1'b0, 1'b0);
    chk(g, 1'b1);
    dma_req <= 8'h00;
    results();
  end
endmodule // test_priority_interrupt_arbiter
